// *** src/adc_pkg.sv ***
`default_nettype none
package adc_pkg;

	// ----------------------------------------
	// Mode and pin function encodings
	// ----------------------------------------
	localparam logic [2:0] MODE_OFF = 3'h0; // Diversity disabled, fixed antenna
	localparam logic [2:0] MODE_ANT_A = 3'h1; // Fixed antenna A
	localparam logic [2:0] MODE_ANT_B = 3'h2; // Fixed antenna B
	// Any other code enables the automatic search

	localparam int PIN_COUNT = 4;
	localparam logic [2:0] FN_LOW = 3'h0;
	localparam logic [2:0] FN_HIGH = 3'h1;
	localparam logic [2:0] FN_ANT_A = 3'h2;
	localparam logic [2:0] FN_ANT_B = 3'h3;
	localparam logic [2:0] FN_TX_RX_SW = 3'h4;
	localparam logic [2:0] FN_CLK_OUT = 3'h5;
	localparam logic [2:0] FN_BUF_STAT = 3'h6;
	localparam logic [2:0] FN_WAKE = 3'h7;

	// ----------------------------------------
	// Timing
	// ----------------------------------------
	localparam int CLK_MHZ = 25;
	localparam int DWELL_NS = 2000; // Time spent on each antenna while searching
	localparam int DWELL_CYC = (DWELL_NS * CLK_MHZ) / 1000;
	localparam int DWELL_W = 8;
	localparam logic [DWELL_W-1:0] DWELL_LAST = DWELL_W'(DWELL_CYC - 1);
	localparam int RSSI_W = 8;

	typedef enum logic [1:0] {
		ADC_IDLE,
		ADC_SEARCH,
		ADC_HOLD
	} adc_state_e;

endpackage : adc_pkg
`default_nettype wire

// *** src/adc_antenna_diversity.sv ***
`timescale 1ns/1ps
`default_nettype none

module adc_antenna_diversity (
	input wire logic clk,
	input wire logic rst_n,
	input wire logic power_off_input,
	input wire logic cfg_we,
	input wire logic [2:0] cfg_mode,
	input wire logic [1:0] cfg_pin_sel,
	input wire logic [2:0] cfg_pin_fn,
	input wire logic rx_enter,
	input wire logic rx_exit,
	input wire logic tx_active,
	input wire logic packet_start,
	input wire logic rssi_valid,
	input wire logic [adc_pkg::RSSI_W-1:0] rssi,
	input wire logic clk_out_src,
	input wire logic buf_stat_src,
	input wire logic wake_src,
	output logic ant_sel_ff,
	output logic searching_ff,
	output logic [adc_pkg::PIN_COUNT-1:0] multi_function_pins
);

	// ----------------------------------------
	// Power-off synchroniser
	// ----------------------------------------
	logic off_s1_ff;
	logic off_s2_ff;
	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			off_s1_ff <= 1'b1;
			off_s2_ff <= 1'b1;
		end else begin
			off_s1_ff <= power_off_input;
			off_s2_ff <= off_s1_ff;
		end
	end

	// ----------------------------------------
	// Configuration store
	// ----------------------------------------
	logic [2:0] mode_ff;
	logic [2:0] nxt_mode;
	logic [2:0] pin_fn_ff [adc_pkg::PIN_COUNT];
	logic [2:0] nxt_pin_fn [adc_pkg::PIN_COUNT];

	// Shutdown wipes everything; host must rewrite after power returns
	always_comb begin
		nxt_mode = mode_ff;
		for (int i = 0; i < adc_pkg::PIN_COUNT; i++) begin
			nxt_pin_fn[i] = pin_fn_ff[i];
		end
		if (off_s2_ff) begin
			nxt_mode = adc_pkg::MODE_OFF;
			for (int i = 0; i < adc_pkg::PIN_COUNT; i++) begin
				nxt_pin_fn[i] = adc_pkg::FN_LOW;
			end
		end else if (cfg_we) begin
			nxt_mode = cfg_mode;
			nxt_pin_fn[cfg_pin_sel] = cfg_pin_fn;
		end
	end

	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			mode_ff <= adc_pkg::MODE_OFF;
			for (int i = 0; i < adc_pkg::PIN_COUNT; i++) begin
				pin_fn_ff[i] <= adc_pkg::FN_LOW;
			end
		end else begin
			mode_ff <= nxt_mode;
			for (int i = 0; i < adc_pkg::PIN_COUNT; i++) begin
				pin_fn_ff[i] <= nxt_pin_fn[i];
			end
		end
	end

	// ----------------------------------------
	// Selection state machine
	// ----------------------------------------
	adc_pkg::adc_state_e state_ff;
	adc_pkg::adc_state_e nxt_state;
	logic nxt_ant_sel;
	logic nxt_searching;
	logic [adc_pkg::DWELL_W-1:0] dwell_ff;
	logic [adc_pkg::DWELL_W-1:0] nxt_dwell;
	logic [adc_pkg::RSSI_W-1:0] peak_a_ff;
	logic [adc_pkg::RSSI_W-1:0] peak_b_ff;
	logic [adc_pkg::RSSI_W-1:0] nxt_peak_a;
	logic [adc_pkg::RSSI_W-1:0] nxt_peak_b;
	logic auto_en;

	assign auto_en = (mode_ff != adc_pkg::MODE_OFF) && (mode_ff != adc_pkg::MODE_ANT_A)
		&& (mode_ff != adc_pkg::MODE_ANT_B);

	// Peak strength per antenna is kept so a late fade on one side cannot flip the choice
	always_comb begin
		nxt_state = state_ff;
		nxt_ant_sel = ant_sel_ff;
		nxt_searching = 1'b0;
		nxt_dwell = dwell_ff;
		nxt_peak_a = peak_a_ff;
		nxt_peak_b = peak_b_ff;
		case (state_ff)
			adc_pkg::ADC_IDLE: begin
				if (mode_ff == adc_pkg::MODE_ANT_B) begin
					nxt_ant_sel = 1'b1;
				end else if (!auto_en) begin
					nxt_ant_sel = 1'b0;
				end
				if (auto_en && rx_enter && !off_s2_ff) begin
					nxt_state = adc_pkg::ADC_SEARCH;
					nxt_searching = 1'b1;
					nxt_dwell = '0;
					nxt_peak_a = '0;
					nxt_peak_b = '0;
				end
			end
			adc_pkg::ADC_SEARCH: begin
				nxt_searching = 1'b1;
				if (rssi_valid) begin
					if (!ant_sel_ff && rssi > peak_a_ff) begin
						nxt_peak_a = rssi;
					end
					if (ant_sel_ff && rssi > peak_b_ff) begin
						nxt_peak_b = rssi;
					end
				end
				if (packet_start) begin
					nxt_state = adc_pkg::ADC_HOLD;
					nxt_searching = 1'b0;
					nxt_ant_sel = (peak_b_ff > peak_a_ff);
				end else if (dwell_ff == adc_pkg::DWELL_LAST) begin
					nxt_dwell = '0;
					nxt_ant_sel = !ant_sel_ff;
				end else begin
					nxt_dwell = dwell_ff + 1'b1;
				end
				if (rx_exit || !auto_en) begin
					nxt_state = adc_pkg::ADC_IDLE;
					nxt_searching = 1'b0;
				end
			end
			adc_pkg::ADC_HOLD: begin
				// Winner stays selected through transmit until the next receive entry, a change to a fixed mode, or power-off
				if (rx_enter && auto_en) begin
					nxt_state = adc_pkg::ADC_SEARCH;
					nxt_searching = 1'b1;
					nxt_dwell = '0;
					nxt_peak_a = '0;
					nxt_peak_b = '0;
				end else if (!auto_en) begin
					nxt_state = adc_pkg::ADC_IDLE;
				end
			end
			default: begin
				nxt_state = adc_pkg::ADC_IDLE;
			end
		endcase
		if (off_s2_ff) begin
			nxt_state = adc_pkg::ADC_IDLE;
			nxt_searching = 1'b0;
			nxt_ant_sel = 1'b0;
		end
	end

	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			state_ff <= adc_pkg::ADC_IDLE;
			ant_sel_ff <= 1'b0;
			searching_ff <= 1'b0;
			dwell_ff <= '0;
			peak_a_ff <= '0;
			peak_b_ff <= '0;
		end else begin
			state_ff <= nxt_state;
			ant_sel_ff <= nxt_ant_sel;
			searching_ff <= nxt_searching;
			dwell_ff <= nxt_dwell;
			peak_a_ff <= nxt_peak_a;
			peak_b_ff <= nxt_peak_b;
		end
	end

	// ----------------------------------------
	// Pin function multiplexer
	// ----------------------------------------
	// Both antenna lines derive from one next-selection value, nxt_ant_sel, so they can never overlap
	logic [adc_pkg::PIN_COUNT-1:0] pins_ff;
	logic [adc_pkg::PIN_COUNT-1:0] nxt_pins;
	always_comb begin
		for (int i = 0; i < adc_pkg::PIN_COUNT; i++) begin
			case (pin_fn_ff[i])
				adc_pkg::FN_LOW: nxt_pins[i] = 1'b0;
				adc_pkg::FN_HIGH: nxt_pins[i] = 1'b1;
				adc_pkg::FN_ANT_A: nxt_pins[i] = !nxt_ant_sel;
				adc_pkg::FN_ANT_B: nxt_pins[i] = nxt_ant_sel;
				adc_pkg::FN_TX_RX_SW: nxt_pins[i] = tx_active;
				adc_pkg::FN_CLK_OUT: nxt_pins[i] = clk_out_src;
				adc_pkg::FN_BUF_STAT: nxt_pins[i] = buf_stat_src;
				adc_pkg::FN_WAKE: nxt_pins[i] = wake_src;
				default: nxt_pins[i] = 1'b0;
			endcase
		end
	end

	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			pins_ff <= '0;
		end else begin
			pins_ff <= nxt_pins;
		end
	end
	assign multi_function_pins = pins_ff;

	// ----------------------------------------
	// Checks
	// ----------------------------------------
	sequence search_start_s;
		state_ff == adc_pkg::ADC_IDLE && auto_en && rx_enter && !off_s2_ff;
	endsequence

	search_entry_a: assert property (@(posedge clk) disable iff (!rst_n)
		search_start_s |=> searching_ff)
		else $error("search did not start on receive entry");
	winner_pick_a: assert property (@(posedge clk) disable iff (!rst_n)
		(state_ff == adc_pkg::ADC_SEARCH && packet_start && !rx_exit && auto_en && !off_s2_ff)
		|=> ant_sel_ff == $past(peak_b_ff > peak_a_ff))
		else $error("wrong antenna chosen");
	hold_stable_a: assert property (@(posedge clk) disable iff (!rst_n)
		(state_ff == adc_pkg::ADC_HOLD && !off_s2_ff && auto_en) |=> $stable(ant_sel_ff))
		else $error("antenna changed while held");
	toggle_dwell_a: assert property (@(posedge clk) disable iff (!rst_n)
		(state_ff == adc_pkg::ADC_SEARCH && dwell_ff == adc_pkg::DWELL_LAST && !packet_start
		&& !off_s2_ff) |=> ant_sel_ff != $past(ant_sel_ff))
		else $error("antenna did not toggle after dwell");
	no_toggle_idle_a: assert property (@(posedge clk) disable iff (!rst_n)
		!auto_en |=> !searching_ff)
		else $error("search running while disabled");
	off_clears_a: assert property (@(posedge clk) disable iff (!rst_n)
		off_s2_ff |=> mode_ff == adc_pkg::MODE_OFF && state_ff == adc_pkg::ADC_IDLE)
		else $error("power-off left configuration");
	ant_pin_a: assert property (@(posedge clk) disable iff (!rst_n)
		(pin_fn_ff[0] == adc_pkg::FN_ANT_A && $stable(pin_fn_ff[0])) |-> pins_ff[0] == !ant_sel_ff)
		else $error("antenna pin not complementary");
	tx_rx_switch_control_pin_a: assert property (@(posedge clk) disable iff (!rst_n)
		(pin_fn_ff[2] == adc_pkg::FN_TX_RX_SW) |=> pins_ff[2] == $past(tx_active))
		else $error("switch pin wrong");

endmodule // adc_antenna_diversity
`default_nettype wire

// *** verification/adc_spdt_switch.sv ***
`timescale 1ns/1ps
`default_nettype none
// --------------------------------
// External two-way antenna switch
// --------------------------------
module adc_spdt_switch (
	input wire logic ctl_a,
	input wire logic ctl_b,
	output logic conn_b,
	output logic fault
);
	// Path B closes only on its own control, so a dead pin pair falls back to A
	assign conn_b = ctl_b & ~ctl_a;
	// Both or neither driven would short or float the antenna feed
	assign fault = ctl_a ~^ ctl_b;
endmodule // adc_spdt_switch
`default_nettype wire

// *** verification/tb_top.sv ***
`timescale 1ns/1ps
`default_nettype none
module tb_top;
	logic clk = 1'b0, rst_n = 1'b0, power_off_input = 1'b0, cfg_we = 1'b0;
	logic [2:0] cfg_mode = 3'h0, cfg_pin_fn = 3'h0;
	logic [1:0] cfg_pin_sel = 2'h0;
	logic rx_enter = 1'b0, rx_exit = 1'b0, tx_active = 1'b0, packet_start = 1'b0;
	logic rssi_valid = 1'b1, clk_out_src = 1'b0, buf_stat_src = 1'b1, wake_src = 1'b1;
	logic [adc_pkg::RSSI_W-1:0] rssi = 8'h00, lvl_a = 8'h00, lvl_b = 8'h00;
	logic ant_sel_ff, searching_ff, conn_b, fault, armed = 1'b0;
	logic [adc_pkg::PIN_COUNT-1:0] multi_function_pins;
	int fail_count = 0, samples_checked = 0;
	always #20 clk = ~clk;
	adc_antenna_diversity adc_antenna_diversity_i (.clk(clk), .rst_n(rst_n), .power_off_input(power_off_input),
		.cfg_we(cfg_we), .cfg_mode(cfg_mode), .cfg_pin_sel(cfg_pin_sel), .cfg_pin_fn(cfg_pin_fn),
		.rx_enter(rx_enter), .rx_exit(rx_exit), .tx_active(tx_active), .packet_start(packet_start),
		.rssi_valid(rssi_valid), .rssi(rssi), .clk_out_src(clk_out_src), .buf_stat_src(buf_stat_src),
		.wake_src(wake_src), .ant_sel_ff(ant_sel_ff), .searching_ff(searching_ff),
		.multi_function_pins(multi_function_pins));
	adc_spdt_switch adc_spdt_switch_i (.ctl_a(multi_function_pins[0]), .ctl_b(multi_function_pins[1]),
		.conn_b(conn_b), .fault(fault));
	// Strength follows the path the switch really closed, not the register
	always @(negedge clk) begin
		rssi <= conn_b ? lvl_b : lvl_a;
		if (armed) chk1("switch_fault", 1'b0, fault);
	end
	// ----------------
	// Compare helpers
	// ----------------
	task automatic chk1(input string what, input logic exp, input logic got);
		samples_checked++;
		if (got !== exp) begin
			fail_count++;
			$display("ERROR %s expected %b seen %b", what, exp, got);
		end
	endtask
	task automatic chk4(input string what, input logic [3:0] exp, input logic [3:0] got);
		samples_checked++;
		if (got !== exp) begin
			fail_count++;
			$display("ERROR %s expected %h seen %h", what, exp, got);
		end
	endtask
	task automatic tally_and_finish();
		if (fail_count == 0 && samples_checked > 0) begin
			$display("DONE - PASS");
		end else begin
			$display("DONE - FAIL");
		end
		$finish;
	endtask
	task automatic cyc(input int n);
		repeat (n) @(negedge clk);
	endtask
	// Write takes both the mode and one pin function; settle before returning
	task automatic cfg(input logic [2:0] mode, input logic [1:0] pin, input logic [2:0] fn);
		cfg_we <= 1'b1;
		cfg_mode <= mode;
		cfg_pin_sel <= pin;
		cfg_pin_fn <= fn;
		cyc(1);
		cfg_we <= 1'b0;
		cyc(2);
	endtask
	task automatic pins_exp(input logic ant);
		chk4("pins", {clk_out_src, tx_active, ant, ~ant}, multi_function_pins);
	endtask
	// -------------------------------------------
	// Scenarios
	// -------------------------------------------
	// Every pin function on pin 3, sources high then low, so each source is seen to pass
	task automatic t_pin_fns();
		for (int f = 0; f < 8; f++) begin
			tx_active = 1'b1;
			clk_out_src = 1'b1;
			buf_stat_src = 1'b1;
			wake_src = 1'b1;
			cfg(3'h3, 2'h3, 3'(f));
			chk1("pin3_fn_hi", !(f == 0 || f == 3), multi_function_pins[3]);
			tx_active = 1'b0;
			clk_out_src = 1'b0;
			buf_stat_src = 1'b0;
			wake_src = 1'b0;
			cyc(2);
			chk1("pin3_fn_lo", (f == 1 || f == 2), multi_function_pins[3]);
		end
		cfg(3'h3, 2'h3, adc_pkg::FN_CLK_OUT);
		tx_active = 1'b0;
		clk_out_src = 1'b0;
		cyc(2);
		pins_exp(1'b0);
	endtask
	// Search alternates from the antenna already selected, then locks onto the stronger peak
	task automatic t_search(input logic [7:0] a, input logic [7:0] b, input logic st, input logic win);
		int n;
		lvl_a = a;
		lvl_b = b;
		rx_enter <= 1'b1;
		cyc(1);
		rx_enter <= 1'b0;
		for (n = 0; n < 4 && searching_ff !== 1'b1; n++) cyc(1);
		if (n == 4) begin
			fail_count++;
			tally_and_finish();
		end
		cyc(25);
		chk1("ant_dwell0", st, ant_sel_ff);
		cyc(50);
		chk1("ant_dwell1", !st, ant_sel_ff);
		pins_exp(!st);
		cyc(50);
		chk1("ant_dwell2", st, ant_sel_ff);
		// Packet start only after a long preamble, so each antenna gets full dwells
		packet_start <= 1'b1;
		cyc(1);
		packet_start <= 1'b0;
		cyc(2);
		chk1("searching", 1'b0, searching_ff);
		chk1("winner", win, ant_sel_ff);
		cyc(120);
		chk1("winner_held", win, ant_sel_ff);
		tx_active = 1'b1;
		cyc(3);
		pins_exp(win);
		tx_active = 1'b0;
		cyc(2);
	endtask
	// Leaving receive mid-search ends the search; mode 7 is an automatic code as well
	task automatic t_rx_exit();
		cfg(3'h7, 2'h3, adc_pkg::FN_CLK_OUT);
		rx_enter <= 1'b1;
		cyc(1);
		rx_enter <= 1'b0;
		cyc(2);
		chk1("search_mode7", 1'b1, searching_ff);
		rx_exit <= 1'b1;
		cyc(1);
		rx_exit <= 1'b0;
		cyc(1);
		chk1("search_exit", 1'b0, searching_ff);
	endtask
	// Fixed modes pick an antenna and refuse the search
	task automatic t_fixed();
		cfg(adc_pkg::MODE_ANT_B, 2'h3, adc_pkg::FN_CLK_OUT);
		chk1("fixed_b", 1'b1, ant_sel_ff);
		pins_exp(1'b1);
		cfg(adc_pkg::MODE_ANT_A, 2'h3, adc_pkg::FN_CLK_OUT);
		chk1("fixed_a", 1'b0, ant_sel_ff);
		cfg(adc_pkg::MODE_OFF, 2'h3, adc_pkg::FN_CLK_OUT);
		rx_enter <= 1'b1;
		cyc(1);
		rx_enter <= 1'b0;
		cyc(3);
		chk1("no_search", 1'b0, searching_ff);
		pins_exp(1'b0);
	endtask
	// Shutdown wipes the pin functions and the mode; writes meanwhile are lost
	task automatic t_power_off();
		cfg(adc_pkg::MODE_ANT_B, 2'h3, adc_pkg::FN_HIGH);
		armed = 1'b0;
		power_off_input = 1'b1;
		cyc(4);
		cfg(3'h3, 2'h2, adc_pkg::FN_HIGH);
		chk4("pins_off", 4'h0, multi_function_pins);
		power_off_input = 1'b0;
		cyc(4);
		rx_enter <= 1'b1;
		cyc(1);
		rx_enter <= 1'b0;
		cyc(3);
		chk4("pins_after", 4'h0, multi_function_pins);
		chk1("ant_after", 1'b0, ant_sel_ff);
		chk1("search_after", 1'b0, searching_ff);
	endtask
	initial begin
		cyc(12);
		rst_n = 1'b1;
		cyc(3);
		chk4("pins_reset", 4'h0, multi_function_pins);
		cfg(3'h3, 2'h0, adc_pkg::FN_ANT_A);
		cfg(3'h3, 2'h1, adc_pkg::FN_ANT_B);
		cfg(3'h3, 2'h2, adc_pkg::FN_TX_RX_SW);
		armed = 1'b1;
		t_pin_fns();
		t_search(8'h20, 8'h90, 1'b0, 1'b1);
		t_search(8'h55, 8'h55, 1'b1, 1'b0);
		t_rx_exit();
		t_fixed();
		t_power_off();
		tally_and_finish();
	end
endmodule // tb_top
`default_nettype wire
